// ==== hdl/bbcd_core.sv ====
// control-flow decoder and sequencer: branches, bit ops, control, jump/call
//
// Overview of operation
// [RL1] short branch: 1 byte, 2 cycles, flags kept
// [RL2] 5-bit signed displacement, reach -15 to +16
// [RL3] bit test-branch: 3 bytes, 5 cycles, updates carry
// [RL4] 8-bit signed displacement, reach -126 to +129
// [RL5] bit set/clear: 2 bytes, 4 cycles
// [RL6] control ops: 1 byte, 2 cycles
// [RL7] hardware watchdog turns stop into wait
// [RL8] jump/call: 12-bit target, 2 bytes, 4 cycles
// [RL9] even low nibbles decode as four branch kinds
// [RL10] low nibbles 1,9,3,b: call, jump, bit ops
// [RL11] illegal opcodes flagged, never executed
// [RL12] opcode bit 4 picks the indirect pointer
// [RL13] untaken branch falls through, same cycle count
`timescale 1ns/1ps

module bbcd_core (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  pm_data_i,
   output logic      [11:0] pm_addr_o,
   input  wire logic [7:0]  ds_rdata_i,
   output bbcd_pkg::bbcd_ds_t ds_o,
   input  wire logic        flag_z_i,
   input  wire logic        flag_c_i,
   output logic             flag_c_we_o,
   output logic             flag_c_o,
   input  wire logic [11:0] ret_addr_i,
   output logic             push_o,
   output logic      [11:0] push_addr_o,
   output logic             ret_o,
   output logic             interrupt_exit_o,
   input  wire logic        wdog_hw_i,
   output logic             stop_o,
   output logic             wait_o,
   input  wire logic        wake_i,
   output logic             illegal_o,
   output logic             ext_go_o,
   output logic      [7:0]  ext_op_o,
   output logic             ind_ptr_y_o,
   input  wire logic        ext_done_i,
   input  wire logic [1:0]  ext_len_i
);
   import bbcd_pkg::*;

   // ---------------------------------------------------------------
   // opcode classification
   // ---------------------------------------------------------------
   function automatic bbcd_class_t classify(input logic [7:0] op);
      bbcd_class_t c;
      c = BBCD_C_EXT;
      if (op[0] == 1'b0) begin
         c = BBCD_C_BR;                                    // [RL9]
      end else begin
         case (op[3:0])
            4'h1:    c = BBCD_C_CALL;                      // [RL10]
            4'h9:    c = BBCD_C_JP;                        // [RL10]
            4'h3:    c = BBCD_C_BT;                        // [RL10]
            4'hb:    c = BBCD_C_BSC;                       // [RL10]
            4'h5:    c = op[4] ? BBCD_C_EXT : BBCD_C_ILL;  // [RL11]
            4'h7: begin
               if (op[7:4] == 4'h7 || op[7:4] == 4'h9 || op[7:4] == 4'hf) begin
                  c = BBCD_C_ILL;                          // [RL11]
               end
            end
            4'hd: begin
               if (op == BBCD_OP_RET || op == BBCD_OP_INTERRUPT_EXIT || op == BBCD_OP_WAIT ||
                   op == BBCD_OP_STOP || op == BBCD_OP_IDLE) begin
                  c = BBCD_C_CTL;
               end else if (op[7:4] == 4'h8) begin
                  c = BBCD_C_ILL;                          // [RL11]
               end
            end
            default: c = BBCD_C_EXT;
         endcase
      end
      return c;
   endfunction : classify

   // bit number sits bit-reversed in opcode bits 7..5
   function automatic logic [2:0] bit_num(input logic [7:0] op);
      return {op[5], op[6], op[7]};
   endfunction : bit_num

   bbcd_regs_t  st_q;
   bbcd_regs_t  st_d;
   bbcd_class_t cls;
   logic        br_taken;
   logic        bt_taken;
   logic [11:0] sext5;
   logic [11:0] sext8;
   logic [7:0]  bmask;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      st_d.cwe    = 1'b0;
      st_d.push   = 1'b0;
      st_d.ret    = 1'b0;
      st_d.interrupt_exit   = 1'b0;
      st_d.stop   = 1'b0;
      st_d.wait_p = 1'b0;
      st_d.ill    = 1'b0;
      st_d.ext_go = 1'b0;
      st_d.ds.we  = 1'b0;
      cls         = classify(st_q.op);
      sext5       = {{7{st_q.op[7]}}, st_q.op[7:3]};       // [RL2]
      sext8       = {{4{st_q.b1[7]}}, st_q.b1};            // [RL4]
      bmask       = 8'h01 << bit_num(st_q.op);
      // condition select by opcode bits 2..1
      case (st_q.op[2:1])
         2'h0:    br_taken = !flag_z_i;                    // [RL9]
         2'h1:    br_taken = !flag_c_i;                    // [RL9]
         2'h2:    br_taken = flag_z_i;                     // [RL9]
         default: br_taken = flag_c_i;                     // [RL9]
      endcase
      bt_taken = (st_q.tbit == st_q.op[4]);                // [RL3]
      case (st_q.state)
         BBCD_S_FETCH: begin
            st_d.op     = pm_data_i;
            st_d.opaddr = st_q.fa;
            st_d.fa     = st_q.fa + BBCD_LEN1;
            st_d.cnt    = 3'h1;
            st_d.state  = BBCD_S_EXEC;
         end
         BBCD_S_EXEC: begin
            st_d.cnt = st_q.cnt + 3'h1;
            case (cls)
               BBCD_C_BR: begin
                  // same length taken or not; flags untouched
                  st_d.fa    = br_taken ? st_q.opaddr + BBCD_LEN1 + sext5
                                        : st_q.opaddr + BBCD_LEN1;  // [RL1] [RL13]
                  st_d.state = BBCD_S_FETCH;
               end
               BBCD_C_BT: begin
                  if (st_q.cnt == 3'h1) begin
                     st_d.ds.addr = pm_data_i;
                     st_d.fa      = st_q.fa + BBCD_LEN1;
                  end else if (st_q.cnt == 3'h2) begin
                     st_d.b1   = pm_data_i;
                     st_d.tbit = ds_rdata_i[bit_num(st_q.op)];
                  end else if (st_q.cnt == BBCD_CYC_BT - 3'h1) begin
                     // taken target counts from two bytes in, so reach is -126..+129
                     st_d.fa    = bt_taken ? st_q.opaddr + BBCD_LEN2 + sext8
                                           : st_q.opaddr + BBCD_LEN3;  // [RL4] [RL13]
                     st_d.cwe   = 1'b1;                    // [RL3]
                     st_d.cval  = st_q.tbit;
                     st_d.state = BBCD_S_FETCH;
                  end
               end
               BBCD_C_BSC: begin
                  if (st_q.cnt == 3'h1) begin
                     st_d.ds.addr = pm_data_i;
                     st_d.fa      = st_q.fa + BBCD_LEN1;
                  end else if (st_q.cnt == 3'h2) begin
                     // read-modify-write of one bit, others preserved
                     st_d.ds.wdata = st_q.op[4] ? (ds_rdata_i | bmask)
                                                : (ds_rdata_i & ~bmask);  // [RL5]
                     st_d.ds.we    = 1'b1;
                  end else if (st_q.cnt == BBCD_CYC_BSC - 3'h1) begin
                     st_d.state = BBCD_S_FETCH;            // [RL5]
                  end
               end
               BBCD_C_JP, BBCD_C_CALL: begin
                  if (st_q.cnt == 3'h1) begin
                     st_d.b1 = pm_data_i;
                     st_d.fa = st_q.fa + BBCD_LEN1;
                  end else if (st_q.cnt == BBCD_CYC_JP - 3'h1) begin
                     st_d.fa       = {st_q.op[7:4], st_q.b1};  // [RL8]
                     st_d.push     = (cls == BBCD_C_CALL);
                     st_d.pushaddr = st_q.opaddr + BBCD_LEN2;
                     st_d.state    = BBCD_S_FETCH;
                  end
               end
               BBCD_C_CTL: begin
                  st_d.state = BBCD_S_FETCH;               // [RL6]
                  if (st_q.op == BBCD_OP_RET) begin
                     st_d.ret = 1'b1;
                     st_d.fa  = ret_addr_i;
                  end else if (st_q.op == BBCD_OP_INTERRUPT_EXIT) begin
                     st_d.interrupt_exit = 1'b1;                     // [RL6]
                     st_d.fa   = ret_addr_i;
                  end else if (st_q.op == BBCD_OP_STOP) begin
                     // watchdog cannot be frozen, so no real stop then
                     st_d.stop   = !wdog_hw_i;             // [RL7]
                     st_d.wait_p = wdog_hw_i;              // [RL7]
                     st_d.state  = BBCD_S_HALT;
                  end else if (st_q.op == BBCD_OP_WAIT) begin
                     st_d.wait_p = 1'b1;
                     st_d.state  = BBCD_S_HALT;
                  end
               end
               BBCD_C_ILL: begin
                  st_d.ill   = 1'b1;                       // [RL11]
                  st_d.state = BBCD_S_FETCH;
               end
               default: begin
                  // hand load/arith ops to the datapath
                  st_d.ext_go = 1'b1;
                  st_d.ptr_y  = st_q.op[4];                // [RL12]
                  st_d.state  = BBCD_S_EXTW;
               end
            endcase
         end
         BBCD_S_EXTW: begin
            if (ext_done_i) begin
               st_d.fa    = st_q.opaddr + {10'h000, ext_len_i};
               st_d.state = BBCD_S_FETCH;
            end
         end
         BBCD_S_HALT: begin
            if (wake_i) begin
               st_d.state = BBCD_S_FETCH;
            end
         end
         default: st_d.state = BBCD_S_FETCH;
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q       <= '0;
         st_q.state <= BBCD_S_FETCH;
         st_q.fa    <= BBCD_RESET_PC;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state record
   assign pm_addr_o   = st_q.fa;
   assign ds_o        = st_q.ds;
   assign flag_c_we_o = st_q.cwe;
   assign flag_c_o    = st_q.cval;
   assign push_o      = st_q.push;
   assign push_addr_o = st_q.pushaddr;
   assign ret_o       = st_q.ret;
   assign interrupt_exit_o      = st_q.interrupt_exit;
   assign stop_o      = st_q.stop;
   assign wait_o      = st_q.wait_p;
   assign illegal_o   = st_q.ill;
   assign ext_go_o    = st_q.ext_go;
   assign ext_op_o    = st_q.op;
   assign ind_ptr_y_o = st_q.ptr_y;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic        fetch_h;
   bbcd_class_t fcls_h;
   logic [11:0] br_tgt_h;
   logic [3:0]  op_hi_h;
   logic [11:0] ee_sx_h;
   assign fetch_h  = (st_q.state == BBCD_S_FETCH);
   assign ee_sx_h  = {{4{pm_data_i[7]}}, pm_data_i};
   assign fcls_h   = classify(pm_data_i);
   assign br_tgt_h = pm_addr_o + BBCD_LEN1 + {{7{pm_data_i[7]}}, pm_data_i[7:3]};
   assign op_hi_h  = pm_data_i[7:4];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_fetch(bbcd_class_t c);
      fetch_h && fcls_h == c;
   endsequence

   chk_branch_len:  assert property (s_fetch(BBCD_C_BR) |-> ##1 !fetch_h ##1 fetch_h && !flag_c_we_o) // [RL1]
      else $error("short branch not two cycles");
   chk_branch_tgt:  assert property (s_fetch(BBCD_C_BR) ##1 br_taken |-> ##1 pm_addr_o == $past(br_tgt_h, 2)) // [RL2]
      else $error("taken short branch target wrong");
   chk_branch_fall: assert property (s_fetch(BBCD_C_BR) ##1 !br_taken |-> ##1 pm_addr_o == $past(pm_addr_o, 2) + BBCD_LEN1) // [RL13]
      else $error("untaken branch does not fall through");
   chk_bt_cycles:   assert property (s_fetch(BBCD_C_BT) |-> ##1 (!fetch_h)[*4] ##1 fetch_h && flag_c_we_o) // [RL3]
      else $error("bit test-branch timing or carry wrong");
   chk_bt_fall:     assert property (s_fetch(BBCD_C_BT) ##4 !bt_taken |-> ##1 pm_addr_o == $past(pm_addr_o, 5) + BBCD_LEN3) // [RL13]
      else $error("bit test-branch fall-through wrong");
   // displacement byte stands on the fetch bus three edges before retire
   chk_bt_tgt:      assert property (s_fetch(BBCD_C_BT) ##4 bt_taken |->
                       ##1 pm_addr_o == $past(pm_addr_o, 5) + BBCD_LEN2 + $past(ee_sx_h, 3)) // [RL4]
      else $error("taken bit test-branch target wrong");
   chk_bsc_write:   assert property (s_fetch(BBCD_C_BSC) |-> ##3 ds_o.we ##1 fetch_h && !ds_o.we) // [RL5]
      else $error("bit set/clear write timing wrong");
   chk_ctl_len:     assert property (s_fetch(BBCD_C_CTL) ##0 pm_data_i == BBCD_OP_IDLE |-> ##2 fetch_h) // [RL6]
      else $error("control op not two cycles");
   chk_stop_wdog:   assert property (wdog_hw_i && $past(wdog_hw_i) |-> !stop_o) // [RL7]
      else $error("stop executed with hardware watchdog");
   chk_jump_tgt:    assert property (s_fetch(BBCD_C_JP) |-> ##4 fetch_h && pm_addr_o[7:0] == $past(pm_data_i, 3) && pm_addr_o[11:8] == $past(op_hi_h, 4)) // [RL8]
      else $error("jump target or timing wrong");
   chk_illegal:     assert property (s_fetch(BBCD_C_ILL) |-> ##2 illegal_o && fetch_h) // [RL11]
      else $error("illegal opcode not flagged");
   chk_ptr_sel:     assert property ($rose(ext_go_o) |-> ind_ptr_y_o == ext_op_o[4] && st_q.state == BBCD_S_EXTW) // [RL12]
      else $error("indirect pointer select wrong");

endmodule : bbcd_core

// ==== hdl/bbcd_pkg.sv ====
// package: constants, opcode classes and state record of the control-flow decoder
package bbcd_pkg;

   // ------------------------------------------------------------------
   // instruction lengths in cycles (last exec count = cycles - 1)
   // ------------------------------------------------------------------
   localparam logic [2:0]  BBCD_CYC_BR     = 3'h2;
   localparam logic [2:0]  BBCD_CYC_BT     = 3'h5;
   localparam logic [2:0]  BBCD_CYC_BSC    = 3'h4;
   localparam logic [2:0]  BBCD_CYC_JP     = 3'h4;
   localparam logic [2:0]  BBCD_CYC_CTL    = 3'h2;

   // ------------------------------------------------------------------
   // addresses, byte lengths and control opcodes
   // ------------------------------------------------------------------
   localparam logic [11:0] BBCD_RESET_PC   = 12'h000;
   localparam logic [11:0] BBCD_LEN1       = 12'h001;
   localparam logic [11:0] BBCD_LEN2       = 12'h002;
   localparam logic [11:0] BBCD_LEN3       = 12'h003;
   localparam logic [7:0]  BBCD_OP_INTERRUPT_EXIT    = 8'h4d;
   localparam logic [7:0]  BBCD_OP_RET     = 8'hcd;
   localparam logic [7:0]  BBCD_OP_WAIT    = 8'hed;
   localparam logic [7:0]  BBCD_OP_STOP    = 8'h6d;
   localparam logic [7:0]  BBCD_OP_IDLE    = 8'h2d;

   typedef enum logic [2:0] {
      BBCD_S_FETCH,
      BBCD_S_EXEC,
      BBCD_S_EXTW,
      BBCD_S_HALT
   } bbcd_state_t;

   typedef enum logic [3:0] {
      BBCD_C_BR,
      BBCD_C_BT,
      BBCD_C_BSC,
      BBCD_C_JP,
      BBCD_C_CALL,
      BBCD_C_CTL,
      BBCD_C_ILL,
      BBCD_C_EXT
   } bbcd_class_t;

   // data-space side outputs travel together
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
   } bbcd_ds_t;

   typedef struct packed {
      bbcd_state_t state;
      logic [2:0]  cnt;
      logic [7:0]  op;
      logic [11:0] opaddr;
      logic [11:0] fa;
      logic [7:0]  b1;
      logic        tbit;
      bbcd_ds_t    ds;
      logic        cwe;
      logic        cval;
      logic        push;
      logic [11:0] pushaddr;
      logic        ret;
      logic        interrupt_exit;
      logic        stop;
      logic        wait_p;
      logic        ill;
      logic        ext_go;
      logic        ptr_y;
   } bbcd_regs_t;

endpackage : bbcd_pkg

// ==== tb/bbcd_pmem.sv ====
// program memory model feeding opcode and operand bytes to the decoder
`timescale 1ns/1ps

module bbcd_pmem (
   input  wire logic [11:0] addr_i,
   output logic      [7:0]  data_o
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] mem [4096];

   // asynchronous read; the bench fills unused space with an illegal
   // opcode so a stray fetch shows up as an unexpected pulse
   assign data_o = mem[addr_i];
endmodule : bbcd_pmem

// ==== tb/tb_top.sv ====
// self-checking bench for the control-flow decoder
`timescale 1ns/1ps

module tb_top;
   import bbcd_pkg::*;

   // ----------------------------------------------------------------
   // signals and notes
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  cyc;
      logic [8:0]  ev;
      logic [11:0] addr;
      logic [15:0] aux;
      logic        dc;
   } bbcd_tb_note_t;

   localparam logic [8:0] E_PUSH = 9'h100, E_RET = 9'h080, E_INTERRUPT_EXIT = 9'h040;
   localparam logic [8:0] E_STOP = 9'h020, E_WAIT = 9'h010, E_ILL = 9'h008;
   localparam logic [8:0] E_EXT  = 9'h004, E_CWE  = 9'h002, E_WE   = 9'h001;
   localparam logic [7:0] ILL_OPS [12] = '{8'h05, 8'h25, 8'h45, 8'h65, 8'h85, 8'ha5,
                                           8'hc5, 8'he5, 8'h77, 8'h97, 8'hf7, 8'h8d};
   localparam logic [7:0] EXT_OPS [4]  = '{8'h07, 8'h17, 8'h8f, 8'h9f};

   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic [7:0]  pm_data_i, ds_rdata_i, ext_op_o, cnt = 8'h00;
   logic [11:0] pm_addr_o, push_addr_o, ret_addr_i = 12'h000;
   logic        flag_z_i = 1'b0, flag_c_i = 1'b0, wdog_hw_i = 1'b0, wake_i = 1'b0;
   logic        ext_done_i = 1'b0;
   logic [1:0]  ext_len_i = 2'h1;
   logic        flag_c_we_o, flag_c_o, push_o, ret_o, interrupt_exit_o, stop_o, wait_o;
   logic        illegal_o, ext_go_o, ind_ptr_y_o;
   bbcd_ds_t    ds_o;
   logic [8:0]  ev;
   logic [15:0] aux;
   logic [7:0]  dsmem [256];
   bbcd_tb_note_t notes [$];
   int          n_mismatch = 0, checks = 0;

   always #5 clk_i = ~clk_i;

   bbcd_core bbcd_core_inst (
      .clk_i(clk_i), .rst_i(rst_i), .pm_data_i(pm_data_i), .pm_addr_o(pm_addr_o),
      .ds_rdata_i(ds_rdata_i), .ds_o(ds_o), .flag_z_i(flag_z_i), .flag_c_i(flag_c_i),
      .flag_c_we_o(flag_c_we_o), .flag_c_o(flag_c_o), .ret_addr_i(ret_addr_i),
      .push_o(push_o), .push_addr_o(push_addr_o), .ret_o(ret_o), .interrupt_exit_o(interrupt_exit_o),
      .wdog_hw_i(wdog_hw_i), .stop_o(stop_o), .wait_o(wait_o), .wake_i(wake_i),
      .illegal_o(illegal_o), .ext_go_o(ext_go_o), .ext_op_o(ext_op_o),
      .ind_ptr_y_o(ind_ptr_y_o), .ext_done_i(ext_done_i), .ext_len_i(ext_len_i));

   bbcd_pmem bbcd_pmem_inst (.addr_i(pm_addr_o), .data_o(pm_data_i));

   // data space answers in the same cycle as its address
   assign ds_rdata_i = dsmem[ds_o.addr];
   assign ev  = {push_o, ret_o, interrupt_exit_o, stop_o, wait_o, illegal_o, ext_go_o,
                 flag_c_we_o, ds_o.we};
   assign aux = push_o ? {4'h0, push_addr_o} : ds_o.we ? {ds_o.addr, ds_o.wdata} :
                ext_go_o ? {7'h0, ind_ptr_y_o, ext_op_o} : {15'h0, flag_c_we_o & flag_c_o};

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [44:0] seen, input logic [44:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic results();
      if (n_mismatch == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic note(input int c, input logic [8:0] e, input logic [11:0] a,
                       input logic d, input logic [15:0] x);
      notes.push_back('{8'(c), e, a, x, d});
   endtask : note

   // a closing wait; its address is left open since halt may park anywhere
   task automatic wt(input int c);
      note(c, E_WAIT, '0, 1'b1, '0);
   endtask : wt

   // reset, blank the rom with an illegal opcode, place the first opcode
   task automatic start(input logic [7:0] op);
      @(negedge clk_i);
      rst_i = 1'b1;
      foreach (bbcd_pmem_inst.mem[i]) bbcd_pmem_inst.mem[i] = 8'h8d;
      bbcd_pmem_inst.mem[0] = op;
      @(negedge clk_i);
      rst_i = 1'b0;
   endtask : start

   // bounded drain of the notes; a hang ends the run
   task automatic fin();
      for (int i = 0; i < 40 && notes.size() != 0; i++) @(negedge clk_i);
      if (notes.size() != 0) begin
         check("timeout", 45'h1, 45'h0);
         results();
      end
      repeat (2) @(negedge clk_i);
   endtask : fin

   // cycles counted from reset release, edge by edge
   always @(posedge clk_i) cnt <= rst_i ? 8'h00 : cnt + 8'h01;

   // every pulse cycle consumes the oldest note
   always @(negedge clk_i) begin
      bbcd_tb_note_t n;
      if (!rst_i && ev !== 9'h000) begin
         if (notes.size() == 0) begin
            check("stray", {cnt, ev, pm_addr_o, aux}, '0);
         end else begin
            n = notes.pop_front();
            check("event", {cnt, ev, n.dc ? n.addr : pm_addr_o, aux},
                  {n.cyc, n.ev, n.addr, n.aux});
         end
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      int          k, d;
      logic        b;
      logic [7:0]  r8, ee, rr;
      logic [11:0] ta;
      void'($urandom(10));
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      // short branches: every condition, both flag levels, both reach limits
      for (k = 0; k < 32; k++) begin
         flag_z_i = k[2];
         flag_c_i = k[3];
         ret_addr_i = 12'h400 | 12'($urandom_range(255));
         ta = k[4] ? 12'hff1 : 12'h010;
         b = (k[0] ? k[3] : k[2]) ~^ k[1];
         start({k[4] ? 5'h10 : 5'h0f, k[1:0], 1'b0});
         bbcd_pmem_inst.mem[1] = BBCD_OP_RET;
         bbcd_pmem_inst.mem[ta] = BBCD_OP_INTERRUPT_EXIT;
         bbcd_pmem_inst.mem[ret_addr_i] = BBCD_OP_WAIT;
         note(4, b ? E_INTERRUPT_EXIT : E_RET, ret_addr_i, 1'b0, '0);
         wt(6);
         fin();
      end
      // bit test-branch and bit set/clear over every bit and both senses
      for (k = 0; k < 16; k++) begin
         r8 = 8'($urandom);
         ee = k == 0 ? 8'h80 : k == 1 ? 8'h7f : {r8[7], 2'b10, r8[4:0]};
         rr = 8'($urandom);
         dsmem[rr] = 8'($urandom);
         ta = (dsmem[rr][k[2:0]] == k[3]) ? 12'(2 + $signed(ee)) : 12'h003;
         start({k[0], k[1], k[2], k[3], 4'h3});
         bbcd_pmem_inst.mem[1] = rr;
         bbcd_pmem_inst.mem[2] = ee;
         bbcd_pmem_inst.mem[3] = BBCD_OP_WAIT;
         bbcd_pmem_inst.mem[ta] = BBCD_OP_WAIT;
         note(5, E_CWE, ta, 1'b0, {15'h0, dsmem[rr][k[2:0]]});
         wt(7);
         fin();
         start({k[0], k[1], k[2], k[3], 4'hb});
         bbcd_pmem_inst.mem[1] = rr;
         bbcd_pmem_inst.mem[2] = BBCD_OP_WAIT;
         r8 = dsmem[rr];
         r8[k[2:0]] = k[3];
         note(3, E_WE, '0, 1'b1, {rr, r8});
         wt(6);
         fin();
      end
      // long jump and call to random 12-bit targets
      for (k = 0; k < 4; k++) begin
         ta = 12'($urandom) | 12'h004;
         start({ta[11:8], k[0] ? 4'h1 : 4'h9});
         bbcd_pmem_inst.mem[1] = ta[7:0];
         bbcd_pmem_inst.mem[ta] = BBCD_OP_WAIT;
         if (k[0]) note(4, E_PUSH, ta, 1'b0, 16'h0002);
         wt(6);
         fin();
      end
      // idle then stop, with and without the hardware watchdog, then wake
      for (k = 0; k < 2; k++) begin
         wdog_hw_i = k[0];
         start(BBCD_OP_IDLE);
         bbcd_pmem_inst.mem[1] = BBCD_OP_STOP;
         bbcd_pmem_inst.mem[2] = BBCD_OP_WAIT;
         note(4, k[0] ? E_WAIT : E_STOP, '0, 1'b1, '0);
         wt(9);
         repeat (6) @(negedge clk_i);
         wake_i = 1'b1;
         @(negedge clk_i);
         wake_i = 1'b0;
         fin();
      end
      // illegal opcodes are skipped
      foreach (ILL_OPS[i]) begin
         start(ILL_OPS[i]);
         bbcd_pmem_inst.mem[1] = BBCD_OP_WAIT;
         note(2, E_ILL, 12'h001, 1'b0, '0);
         wt(4);
         fin();
      end
      // hand-off of other opcodes, pointer choice, late completion
      foreach (EXT_OPS[i]) begin
         d = 3 + int'($urandom_range(2));
         ext_len_i = 2'($urandom_range(2) + 1);
         start(EXT_OPS[i]);
         bbcd_pmem_inst.mem[{10'h0, ext_len_i}] = BBCD_OP_WAIT;
         note(2, E_EXT, '0, 1'b1, {7'h0, EXT_OPS[i][4], EXT_OPS[i]});
         wt(d + 3);
         repeat (d) @(negedge clk_i);
         ext_done_i = 1'b1;
         @(negedge clk_i);
         ext_done_i = 1'b0;
         fin();
      end
      results();
   end
endmodule : tb_top
